// >>> verilog/spzu_pkg.sv
// Constants shared by the serial port zero design
package spzu_pkg;
	localparam logic [4:0] OFF_CTRL = 5'h00;
	localparam logic [4:0] OFF_DATA = 5'h04;
	localparam logic [4:0] OFF_BAUD = 5'h08;
	localparam logic [4:0] OFF_RELOAD = 5'h0c;
	localparam logic [4:0] OFF_T1RELOAD = 5'h10;
	localparam int B_MODE_HI = 7;
	localparam int B_MODE_LO = 6;
	localparam int B_MPEN = 5;
	localparam int B_REN = 4;
	localparam int B_TB8 = 3;
	localparam int B_RB8 = 2;
	localparam int B_TI = 1;
	localparam int B_RI = 0;
	localparam int B_DOUBLE_RATE_BIT = 0;
	localparam int B_SRC = 1;
	localparam int B_TIMER_ONE_PRESCALE = 2;
	localparam int B_RGPS = 4;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [5:0] BAUD_RESET = 6'h00;
	localparam logic [9:0] RELOAD_RESET = 10'h000;
	localparam logic [7:0] T1RELOAD_RESET = 8'h00;
	// Timer 1 prescale: osc/12, osc, osc/96
	localparam logic [6:0] T1_DIV12 = 7'h0b;
	localparam logic [6:0] T1_DIV1 = 7'h00;
	localparam logic [6:0] T1_DIV96 = 7'h5f;
	// Reload generator prescale; with 8 ticks per bit gives 64, 32, 16, 8
	localparam logic [2:0] RG_DIV8 = 3'h7;
	localparam logic [2:0] RG_DIV4 = 3'h3;
	localparam logic [2:0] RG_DIV2 = 3'h1;
	localparam logic [2:0] RG_DIV1 = 3'h0;
	// Sample ticks per serial bit
	localparam logic [6:0] TPB_SHIFT = 7'h0c;
	localparam logic [6:0] TPB_FIX_SLOW = 7'h40;
	localparam logic [6:0] TPB_FIX_FAST = 7'h20;
	localparam logic [6:0] TPB_T1_SLOW = 7'h20;
	localparam logic [6:0] TPB_T1_FAST = 7'h10;
	localparam logic [6:0] TPB_RG_SLOW = 7'h08;
	localparam logic [6:0] TPB_RG_FAST = 7'h04;
	localparam logic [3:0] FRAME8 = 4'ha;
	localparam logic [3:0] FRAME9 = 4'hb;
	localparam logic [3:0] SHIFT_BITS = 4'h8;
	typedef enum logic [1:0] {
		MODE_SHIFT = 2'b00,
		MODE_UART8 = 2'b01,
		MODE_UART9_FIX = 2'b10,
		MODE_UART9_VAR = 2'b11
	} spzu_mode_type;
	typedef enum logic [1:0] {
		TX_IDLE = 2'b00,
		TX_ASYNC = 2'b01,
		TX_SYNC = 2'b10
	} spzu_tx_state_type;
	typedef enum logic [1:0] {
		RX_IDLE = 2'b00,
		RX_START = 2'b01,
		RX_DATA = 2'b10,
		RX_SYNC = 2'b11
	} spzu_rx_state_type;
endpackage

// >>> verilog/spzu_ctr_if.sv
// Carrier between the port and one reload counter
`timescale 1ns/100ps
`default_nettype none
interface spzu_ctr_if #(parameter int W = 8);
	logic tick;
	logic [W-1:0] reload;
	logic ovf;
	modport owner(output tick, output reload, input ovf);
	modport ctr(input tick, input reload, output ovf);
endinterface
`default_nettype wire

// >>> verilog/spzu_reload_ctr.sv
// Up counter that reloads on overflow
`timescale 1ns/100ps
`default_nettype none
module spzu_reload_ctr #(parameter int W = 8) (
	input wire logic pclk, // System clock
	input wire logic presetn, // Async reset, active low
	spzu_ctr_if.ctr bus // Tick in, reload in, overflow out
);
	logic [W-1:0] count;
	logic at_top;
	assign at_top = &count;
	// Period is two to the W minus reload ticks
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= '0;
			bus.ovf <= 1'b0;
		end else begin
			bus.ovf <= bus.tick && at_top;
			if (bus.tick) begin
				count <= at_top ? bus.reload : count + 1'b1;
			end
		end
	end
endmodule // spzu_reload_ctr
`default_nettype wire

// >>> verilog/spzu_serial_port.sv
// Serial port zero: four-mode UART with APB registers
`timescale 1ns/100ps
`default_nettype none
module spzu_serial_port (
	input wire logic pclk, // System clock, the oscillator
	input wire logic presetn, // Async reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB write
	input wire logic [31:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error, unmapped address
	input wire logic serial_rx_pin_in, // Receive pin level
	output logic serial_rx_pin_out, // Receive pin drive, shift mode
	output logic serial_rx_pin_oe, // Receive pin drive enable
	output logic serial_tx_pin // Transmit line or shift clock
);
	logic [7:0] ctrl;
	logic [5:0] baud;
	logic [9:0] reload_gen_value;
	logic [7:0] timer_one_reload_high;
	logic [7:0] rx_buf;
	logic [7:0] tx_data;

	spzu_pkg::spzu_mode_type mode;
	assign mode = spzu_pkg::spzu_mode_type'(ctrl[spzu_pkg::B_MODE_HI:spzu_pkg::B_MODE_LO]);
	wire multiproc_enable = ctrl[spzu_pkg::B_MPEN];
	wire receive_enable_bit = ctrl[spzu_pkg::B_REN];
	wire tx_ninth_bit = ctrl[spzu_pkg::B_TB8];
	wire rx_done_flag = ctrl[spzu_pkg::B_RI];
	wire double_rate_bit = baud[spzu_pkg::B_DOUBLE_RATE_BIT];
	wire baud_source_select = baud[spzu_pkg::B_SRC];
	wire [1:0] timer_one_prescale = baud[spzu_pkg::B_TIMER_ONE_PRESCALE+1:spzu_pkg::B_TIMER_ONE_PRESCALE];
	wire [1:0] reload_gen_prescale = baud[spzu_pkg::B_RGPS+1:spzu_pkg::B_RGPS];

	// APB decode
	wire setup = psel && !penable;
	wire access = psel && penable;
	wire sel_ctrl = paddr[31:0] == {27'h0, spzu_pkg::OFF_CTRL};
	wire sel_data = paddr[31:0] == {27'h0, spzu_pkg::OFF_DATA};
	wire sel_baud = paddr[31:0] == {27'h0, spzu_pkg::OFF_BAUD};
	wire sel_rel = paddr[31:0] == {27'h0, spzu_pkg::OFF_RELOAD};
	wire sel_t1 = paddr[31:0] == {27'h0, spzu_pkg::OFF_T1RELOAD};
	wire mapped = sel_ctrl || sel_data || sel_baud || sel_rel || sel_t1;
	wire wr_ctrl = access && pwrite && sel_ctrl;
	wire wr_data = access && pwrite && sel_data;
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (sel_ctrl) begin
			rd_mux = {24'h0, ctrl};
		end else if (sel_data) begin
			rd_mux = {24'h0, rx_buf};
		end else if (sel_baud) begin
			rd_mux = {26'h0, baud};
		end else if (sel_rel) begin
			rd_mux = {22'h0, reload_gen_value};
		end else if (sel_t1) begin
			rd_mux = {24'h0, timer_one_reload_high};
		end
	end

	// Baud sources
	logic [6:0] t1_pre;
	logic [2:0] rg_pre;
	logic [6:0] t1_lim;
	logic [2:0] rg_lim;
	always_comb begin
		case (timer_one_prescale)
			2'b00: t1_lim = spzu_pkg::T1_DIV12;
			2'b01: t1_lim = spzu_pkg::T1_DIV1;
			default: t1_lim = spzu_pkg::T1_DIV96;
		endcase
		case (reload_gen_prescale)
			2'b00: rg_lim = spzu_pkg::RG_DIV8;
			2'b01: rg_lim = spzu_pkg::RG_DIV4;
			2'b10: rg_lim = spzu_pkg::RG_DIV2;
			default: rg_lim = spzu_pkg::RG_DIV1;
		endcase
	end
	spzu_ctr_if #(.W(8)) t1_if();
	spzu_ctr_if #(.W(10)) rg_if();
	assign t1_if.tick = t1_pre >= t1_lim;
	assign t1_if.reload = timer_one_reload_high;
	assign rg_if.tick = rg_pre >= rg_lim;
	assign rg_if.reload = reload_gen_value;
	spzu_reload_ctr #(.W(8)) u_timer_one (.pclk(pclk), .presetn(presetn), .bus(t1_if.ctr));
	spzu_reload_ctr #(.W(10)) u_reload_gen (.pclk(pclk), .presetn(presetn), .bus(rg_if.ctr));

	// Sample tick and ticks per bit for the current mode
	logic tick;
	logic [6:0] tpb;
	always_comb begin
		case (mode)
			spzu_pkg::MODE_SHIFT: begin
				tick = 1'b1;
				tpb = spzu_pkg::TPB_SHIFT;
			end
			spzu_pkg::MODE_UART9_FIX: begin
				tick = 1'b1;
				tpb = double_rate_bit ? spzu_pkg::TPB_FIX_FAST : spzu_pkg::TPB_FIX_SLOW;
			end
			default: begin
				// Modes 1 and 3 share the variable source
				if (baud_source_select) begin
					tick = rg_if.ovf;
					tpb = double_rate_bit ? spzu_pkg::TPB_RG_FAST : spzu_pkg::TPB_RG_SLOW;
				end else begin
					tick = t1_if.ovf;
					tpb = double_rate_bit ? spzu_pkg::TPB_T1_FAST : spzu_pkg::TPB_T1_SLOW;
				end
			end
		endcase
	end
	wire [6:0] last_tick = tpb - 7'h01;
	wire [6:0] half_tick = {1'b0, tpb[6:1]} - 7'h01;
	wire nine_bit = mode[1];

	// Transmitter
	spzu_pkg::spzu_tx_state_type tx_state;
	logic [10:0] tx_shift;
	logic [3:0] tx_bits;
	logic [6:0] tx_cnt;
	wire tx_bit_end = tick && (tx_cnt == last_tick);
	wire tx_start = wr_data && (tx_state == spzu_pkg::TX_IDLE);
	logic tx_finish;
	assign tx_finish = (tx_state != spzu_pkg::TX_IDLE) && tx_bit_end && (tx_bits == 4'h1);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_state <= spzu_pkg::TX_IDLE;
			tx_shift <= 11'h7ff;
			tx_bits <= 4'h0;
			tx_cnt <= 7'h00;
		end else begin
			case (tx_state)
				spzu_pkg::TX_IDLE: begin
					tx_cnt <= 7'h00;
					if (tx_start) begin
						if (mode == spzu_pkg::MODE_SHIFT) begin
							tx_state <= spzu_pkg::TX_SYNC;
							tx_shift <= {3'h7, pwdata[7:0]};
							tx_bits <= spzu_pkg::SHIFT_BITS;
						end else begin
							tx_state <= spzu_pkg::TX_ASYNC;
							if (nine_bit) begin
								tx_shift <= {tx_ninth_bit, pwdata[7:0], 1'b0, 1'b1};
								tx_bits <= spzu_pkg::FRAME9;
							end else begin
								tx_shift <= {1'b1, pwdata[7:0], 1'b0, 1'b1};
								tx_bits <= spzu_pkg::FRAME8;
							end
						end
					end
				end
				default: begin
					if (tick) begin
						tx_cnt <= tx_bit_end ? 7'h00 : tx_cnt + 7'h01;
					end
					if (tx_bit_end) begin
						tx_bits <= tx_bits - 4'h1;
						tx_shift <= {1'b1, tx_shift[10:1]};
						if (tx_bits == 4'h1) begin
							tx_state <= spzu_pkg::TX_IDLE;
						end
					end
				end
			endcase
		end
	end
	// Async shift holds an idle one below the frame; the line reads bit 1, so the start bit goes out at once
	wire tx_async_line = (tx_state == spzu_pkg::TX_ASYNC) ? tx_shift[1] : 1'b1;

	// Receiver
	spzu_pkg::spzu_rx_state_type rx_state;
	logic [7:0] rx_data;
	logic rx_ninth;
	logic [3:0] rx_idx;
	logic [6:0] rx_cnt;
	logic rxd_q;
	logic rxd_prev;
	wire async_mode = mode != spzu_pkg::MODE_SHIFT;
	wire rx_last_idx = rx_idx == (nine_bit ? 4'h9 : 4'h8);
	wire rx_sample = tick && (rx_cnt == last_tick);
	wire sync_sample = rx_cnt == {1'b0, spzu_pkg::TPB_SHIFT[6:1]};
	logic rx_finish;
	logic rx_accept;
	always_comb begin
		rx_finish = 1'b0;
		if (rx_state == spzu_pkg::RX_DATA) begin
			rx_finish = rx_sample && rx_last_idx;
		end else if (rx_state == spzu_pkg::RX_SYNC) begin
			rx_finish = (rx_cnt == last_tick) && (rx_idx == 4'h7);
		end
	end
	// Stop bit of mode 1 lands in rx_ninth through index 8
	wire ninth_now = (rx_state == spzu_pkg::RX_DATA && rx_idx == 4'h8) ? rxd_q : rx_ninth;
	assign rx_accept = rx_finish && !(multiproc_enable && nine_bit && !ninth_now);
	wire rx_sync_go = !async_mode && receive_enable_bit && !rx_done_flag && (tx_state == spzu_pkg::TX_IDLE);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_state <= spzu_pkg::RX_IDLE;
			rx_data <= 8'h00;
			rx_ninth <= 1'b0;
			rx_idx <= 4'h0;
			rx_cnt <= 7'h00;
			rxd_q <= 1'b1;
			rxd_prev <= 1'b1;
		end else begin
			rxd_q <= serial_rx_pin_in;
			rxd_prev <= rxd_q;
			case (rx_state)
				spzu_pkg::RX_IDLE: begin
					rx_cnt <= 7'h00;
					rx_idx <= 4'h0;
					if (async_mode && receive_enable_bit && rxd_prev && !rxd_q) begin
						rx_state <= spzu_pkg::RX_START;
					end else if (rx_sync_go) begin
						rx_state <= spzu_pkg::RX_SYNC;
					end
				end
				spzu_pkg::RX_START: begin
					if (tick) begin
						rx_cnt <= rx_cnt + 7'h01;
						if (rx_cnt == half_tick) begin
							rx_cnt <= 7'h00;
							// A short glitch is not a start bit
							rx_state <= rxd_q ? spzu_pkg::RX_IDLE : spzu_pkg::RX_DATA;
						end
					end
				end
				spzu_pkg::RX_DATA: begin
					if (tick) begin
						rx_cnt <= rx_sample ? 7'h00 : rx_cnt + 7'h01;
					end
					if (rx_sample) begin
						rx_idx <= rx_idx + 4'h1;
						if (rx_idx < 4'h8) begin
							rx_data[rx_idx[2:0]] <= rxd_q;
						end else if (rx_idx == 4'h8) begin
							rx_ninth <= rxd_q;
						end
						if (rx_last_idx) begin
							rx_state <= spzu_pkg::RX_IDLE;
						end
					end
				end
				default: begin
					rx_cnt <= (rx_cnt == last_tick) ? 7'h00 : rx_cnt + 7'h01;
					if (sync_sample) begin
						rx_data[rx_idx[2:0]] <= serial_rx_pin_in;
					end
					if (rx_cnt == last_tick) begin
						rx_idx <= rx_idx + 4'h1;
						if (rx_idx == 4'h7) begin
							rx_state <= spzu_pkg::RX_IDLE;
						end
					end
				end
			endcase
		end
	end
	// Buffer takes rx_data unchanged, as the last sample lands in it at mid-bit before the finish
	logic [7:0] rx_final;
	always_comb begin
		rx_final = rx_data;
		if (rx_state == spzu_pkg::RX_SYNC && rx_idx == 4'h7) begin
			rx_final = rx_data;
		end
	end

	// Shift-mode pin drive: low half then high half of each bit
	wire sync_active = (tx_state == spzu_pkg::TX_SYNC) || (rx_state == spzu_pkg::RX_SYNC);
	wire [6:0] sync_cnt = (tx_state == spzu_pkg::TX_SYNC) ? tx_cnt : rx_cnt;
	wire next_tx_pin = sync_active ? (sync_cnt >= {1'b0, spzu_pkg::TPB_SHIFT[6:1]}) : tx_async_line;
	wire next_rx_oe = tx_state == spzu_pkg::TX_SYNC;
	wire next_rx_out = tx_shift[0];

	// Registers and flags; hardware set wins over a software clear
	logic [7:0] next_ctrl;
	always_comb begin
		next_ctrl = ctrl;
		if (wr_ctrl) begin
			next_ctrl = pwdata[7:0];
		end
		if (tx_finish) begin
			next_ctrl[spzu_pkg::B_TI] = 1'b1;
		end
		if (rx_accept) begin
			next_ctrl[spzu_pkg::B_RI] = 1'b1;
			next_ctrl[spzu_pkg::B_RB8] = (rx_state == spzu_pkg::RX_SYNC) ? ctrl[spzu_pkg::B_RB8] : ninth_now;
		end
	end
	// Buffer only changes on a completed frame, so the previous byte survives reception
	wire [7:0] next_rx_buf = rx_accept ? ((rx_state == spzu_pkg::RX_DATA) ? rx_data : rx_final) : rx_buf;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= spzu_pkg::CTRL_RESET;
			baud <= spzu_pkg::BAUD_RESET;
			reload_gen_value <= spzu_pkg::RELOAD_RESET;
			timer_one_reload_high <= spzu_pkg::T1RELOAD_RESET;
			rx_buf <= 8'h00;
			tx_data <= 8'h00;
			t1_pre <= 7'h00;
			rg_pre <= 3'h0;
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
			serial_tx_pin <= 1'b1;
			serial_rx_pin_out <= 1'b1;
			serial_rx_pin_oe <= 1'b0;
		end else begin
			ctrl <= next_ctrl;
			rx_buf <= next_rx_buf;
			t1_pre <= t1_if.tick ? 7'h00 : t1_pre + 7'h01;
			rg_pre <= rg_if.tick ? 3'h0 : rg_pre + 3'h1;
			if (access && pwrite && sel_baud) begin
				baud <= pwdata[5:0];
			end
			if (access && pwrite && sel_rel) begin
				reload_gen_value <= pwdata[9:0];
			end
			if (access && pwrite && sel_t1) begin
				timer_one_reload_high <= pwdata[7:0];
			end
			if (tx_start) begin
				tx_data <= pwdata[7:0];
			end
			pready <= 1'b1;
			if (setup) begin
				prdata <= pwrite ? 32'h0000_0000 : rd_mux;
				pslverr <= !mapped;
			end
			serial_tx_pin <= next_tx_pin;
			serial_rx_pin_out <= next_rx_out;
			serial_rx_pin_oe <= next_rx_oe;
		end
	end
endmodule // spzu_serial_port
`default_nettype wire

// >>> sim/spzu_monitor.sv
// Checker on the serial port top pins
`timescale 1ns/100ps
`default_nettype none
module spzu_monitor (
	input wire logic pclk, // Clock
	input wire logic presetn, // Reset
	input wire logic psel, // APB
	input wire logic penable, // APB
	input wire logic pwrite, // APB
	input wire logic [31:0] paddr, // APB
	input wire logic [31:0] pwdata, // APB
	input wire logic [31:0] prdata, // APB
	input wire logic pready, // APB
	input wire logic pslverr, // APB
	input wire logic serial_rx_pin_in, // Rx level
	input wire logic serial_rx_pin_out, // Rx drive
	input wire logic serial_rx_pin_oe, // Rx enable
	input wire logic serial_tx_pin // Tx pin
);
	default clocking mon_cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	logic [7:0] oe_cnt;
	wire logic acc = psel && penable;
	wire logic mapped = paddr[31:5] == 27'h0 && paddr[4:0] inside {spzu_pkg::OFF_CTRL, spzu_pkg::OFF_DATA,
		spzu_pkg::OFF_BAUD, spzu_pkg::OFF_RELOAD, spzu_pkg::OFF_T1RELOAD};
	// Shift-mode drive length, judged when the pin is let go
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			oe_cnt <= 8'h00;
		else
			oe_cnt <= serial_rx_pin_oe ? oe_cnt + 8'h01 : 8'h00;
	end
	a_ready_always: assert property (acc |-> pready)
		else $error("pready low in access phase");
	a_unmapped_err: assert property (acc && !mapped |-> pslverr)
		else $error("no error on unmapped address");
	a_mapped_ok: assert property (acc && mapped |-> !pslverr)
		else $error("error on mapped address");
	a_unmapped_zero: assert property (acc && !pwrite && !mapped |-> prdata == 32'h0)
		else $error("unmapped read not zero");
	a_shift_low: assert property ($fell(serial_tx_pin) && serial_rx_pin_oe |-> !serial_tx_pin [*6] ##1 serial_tx_pin)
		else $error("shift clock low phase wrong");
	a_shift_high: assert property ($rose(serial_tx_pin) && serial_rx_pin_oe |-> serial_tx_pin [*6])
		else $error("shift clock high phase short");
	a_data_steady: assert property ($rose(serial_tx_pin) && serial_rx_pin_oe |-> $stable(serial_rx_pin_out))
		else $error("shift data moved at clock rise");
	a_oe_frame: assert property ($fell(serial_rx_pin_oe) |-> oe_cnt >= 8'h5e && oe_cnt <= 8'h62)
		else $error("shift transfer length wrong");
	a_async_low: assert property ($fell(serial_tx_pin) && !serial_rx_pin_oe |-> !serial_tx_pin [*4])
		else $error("tx low shorter than a bit");
	a_async_high: assert property ($rose(serial_tx_pin) && !serial_rx_pin_oe |-> serial_tx_pin [*4])
		else $error("tx high shorter than a bit");
endmodule // spzu_monitor
`default_nettype wire

// >>> sim/spzu_partner.sv
// Behavioural remote serial device on the far side of the port
`timescale 1ns/100ps
`default_nettype none
module spzu_partner (
	input wire logic pclk, // Clock
	input wire logic line_in, // Device tx pin
	input wire logic pin_level, // Resolved rx pin
	output logic line_out // Our rx pin drive
);
	logic [7:0] cap = 8'h00;
	logic [7:0] sh = 8'hff;
	logic sync_on = 1'b0;
	logic prev_tx = 1'b1;
	initial line_out = 1'b1;
	// Shift mode: take data on the rising clock, present ours on the falling one
	always @(posedge pclk) begin
		prev_tx <= line_in;
		if (line_in && !prev_tx)
			cap <= {pin_level, cap[7:1]};
		if (sync_on && !line_in && prev_tx) begin
			line_out <= sh[0];
			sh <= {~sh[0], sh[7:1]};
		end
	end
	task automatic sync_load(input logic [7:0] d, input logic on);
		@(posedge pclk);
		sh <= d;
		sync_on <= on;
	endtask
	task automatic send(input logic [8:0] d, input int nb, input int bt);
		@(posedge pclk);
		line_out <= 1'b0;
		repeat (bt) @(posedge pclk);
		for (int i = 0; i < nb; i++) begin
			line_out <= d[i];
			repeat (bt) @(posedge pclk);
		end
		line_out <= 1'b1;
		repeat (bt) @(posedge pclk);
	endtask
	task automatic pulse(input int n);
		@(posedge pclk);
		line_out <= 1'b0;
		repeat (n) @(posedge pclk);
		line_out <= 1'b1;
	endtask
	// Start bit may be short, as it waits for the next baud tick; low returns the first high run after it
	task automatic recv(input int nb, input int bt, output logic [8:0] d, output int low);
		d = 9'h000;
		low = 0;
		do @(posedge pclk); while (line_in !== 1'b0);
		while (line_in === 1'b0) @(posedge pclk);
		fork
			while (line_in === 1'b1) begin
				low++;
				@(posedge pclk);
			end
			begin
				repeat (bt / 2) @(posedge pclk);
				for (int i = 0; i < nb; i++) begin
					d[i] = line_in;
					repeat (bt) @(posedge pclk);
				end
			end
		join
	endtask
endmodule // spzu_partner
`default_nettype wire

// >>> sim/tb_serial_port_zero_uart.sv
// Self-checking bench for the serial port zero UART
`timescale 1ns/100ps
`default_nettype none
module tb_serial_port_zero_uart;
	typedef struct {logic [7:0] ctrl; logic [5:0] baud; logic [9:0] rl; logic [7:0] t1; logic [7:0] d; int nb; int bt;} spzu_row_type;
	localparam logic [31:0] A_CTRL = {27'h0, spzu_pkg::OFF_CTRL};
	localparam logic [31:0] A_DATA = {27'h0, spzu_pkg::OFF_DATA};
	localparam logic [31:0] A_BAUD = {27'h0, spzu_pkg::OFF_BAUD};
	localparam logic [31:0] A_RL = {27'h0, spzu_pkg::OFF_RELOAD};
	localparam logic [31:0] A_T1 = {27'h0, spzu_pkg::OFF_T1RELOAD};
	spzu_row_type rows [9] = '{'{8'h50, 6'h33, 10'h3ff, 8'h00, 8'ha5, 8, 4}, '{8'h50, 6'h22, 10'h3fe, 8'h00, 8'h3b, 8, 32},
		'{8'h50, 6'h13, 10'h3fd, 8'h00, 8'h0f, 8, 48}, '{8'hd8, 6'h02, 10'h3ff, 8'h00, 8'h81, 9, 64},
		'{8'hd0, 6'h05, 10'h000, 8'hff, 8'hc3, 9, 16}, '{8'h50, 6'h01, 10'h000, 8'hff, 8'h55, 8, 192},
		'{8'h50, 6'h09, 10'h000, 8'hff, 8'h99, 8, 1536}, '{8'h98, 6'h01, 10'h000, 8'h00, 8'h6d, 9, 32},
		'{8'h90, 6'h00, 10'h000, 8'h00, 8'he7, 9, 64}};
	logic [31:0] adr [5] = '{A_CTRL, A_DATA, A_BAUD, A_RL, A_T1};
	logic [31:0] msk [5] = '{32'h0, 32'h0, 32'h3f, 32'h3ff, 32'hff};
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, e;
	logic [31:0] paddr = 32'h0, pwdata = 32'h0, r;
	logic [8:0] got;
	int low, n1, miscompares = 0, tests_run = 0, cycles = 0;
	wire [31:0] prdata;
	wire pready, pslverr, rx_out, rx_oe, tx_pin, line_out;
	wire rx_level = rx_oe ? rx_out : line_out;
	always #2 pclk = ~pclk;
	spzu_serial_port spzu_serial_port_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.serial_rx_pin_in(rx_level), .serial_rx_pin_out(rx_out), .serial_rx_pin_oe(rx_oe), .serial_tx_pin(tx_pin));
	spzu_partner spzu_partner_inst (.pclk(pclk), .line_in(tx_pin), .pin_level(rx_level), .line_out(line_out));
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		tests_run++;
		if (g !== x) begin
			miscompares++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask
	task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [31:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk(r, x);
	endtask
	// Polls the control flags; the cycle limit catches a flag that never comes
	task automatic wait_flag(input logic [7:0] m);
		do apb(1'b0, A_CTRL, 32'h0); while ((r[7:0] & m) !== m);
	endtask
	task automatic test_done();
		$display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 60000) begin
			miscompares++;
			test_done();
		end
	end
	initial begin
		repeat (10) @(posedge pclk);
		chk({29'h0, tx_pin, rx_oe, pready}, 32'h4);
		presetn <= 1'b1;
		for (int i = 0; i < 5; i++) begin
			rd(adr[i], 32'h0);
			wr(adr[i], msk[i]);
			rd(adr[i], msk[i]);
		end
		wr(32'h14, 32'hff);
		chk({31'h0, e}, 32'h1);
		rd(32'h14, 32'h0);
		// The data write above started a shift-mode transfer; let it finish
		wait_flag(8'h02);
		wr(A_CTRL, 32'h0);
		rd(A_CTRL, 32'h0);
		$display("Register test done");
		foreach (rows[i]) begin
			wr(A_BAUD, 32'(rows[i].baud));
			wr(A_RL, 32'(rows[i].rl));
			wr(A_T1, 32'(rows[i].t1));
			wr(A_CTRL, 32'(rows[i].ctrl));
			// Reload counters only take a new reload at overflow, so give them time to reach it
			repeat (1100) @(posedge pclk);
			fork
				spzu_partner_inst.recv(rows[i].nb, rows[i].bt, got, low);
				wr(A_DATA, 32'(rows[i].d));
				spzu_partner_inst.send({rows[i].ctrl[3], rows[i].d ^ 8'h3c}, rows[i].nb, rows[i].bt);
			join
			wait_flag(8'h03);
			rd(A_DATA, 32'(rows[i].d ^ 8'h3c));
			rd(A_CTRL, {24'h0, rows[i].ctrl[7:3], rows[i].nb == 9 ? rows[i].ctrl[3] : 1'b1, 2'b11});
			chk(32'(got), {23'h0, rows[i].nb == 9 && rows[i].ctrl[3], rows[i].d});
			n1 = 0;
			while (rows[i].d[n1]) n1++;
			chk(low, rows[i].bt * n1);
			wr(A_CTRL, 32'h0);
			rd(A_CTRL, 32'h0);
			$display("Frame test %0d done", i);
		end
		wr(A_BAUD, 32'h33);
		wr(A_RL, 32'h3ff);
		wr(A_CTRL, 32'hf0);
		repeat (1100) @(posedge pclk);
		spzu_partner_inst.send(9'h012, 9, 4);
		repeat (20) @(posedge pclk);
		rd(A_CTRL, 32'hf0);
		rd(A_DATA, 32'(rows[8].d ^ 8'h3c));
		spzu_partner_inst.send(9'h134, 9, 4);
		wait_flag(8'h01);
		rd(A_DATA, 32'h34);
		rd(A_CTRL, 32'hf5);
		wr(A_CTRL, 32'h40);
		spzu_partner_inst.send(9'h0aa, 8, 4);
		wr(A_CTRL, 32'h50);
		spzu_partner_inst.pulse(1);
		repeat (60) @(posedge pclk);
		rd(A_CTRL, 32'h50);
		$display("Filter test done");
		fork
			begin
				spzu_partner_inst.send(9'h061, 8, 4);
				spzu_partner_inst.send(9'h062, 8, 4);
			end
			begin
				wait_flag(8'h01);
				rd(A_DATA, 32'h61);
				wr(A_CTRL, 32'h50);
			end
		join
		wait_flag(8'h01);
		rd(A_DATA, 32'h62);
		wr(A_CTRL, 32'h0);
		wr(A_DATA, 32'h96);
		wr(A_DATA, 32'h5a);
		wait_flag(8'h02);
		chk(32'(spzu_partner_inst.cap), 32'h96);
		spzu_partner_inst.sync_load(8'h4e, 1'b1);
		wr(A_CTRL, 32'h10);
		wait_flag(8'h01);
		rd(A_DATA, 32'h4e);
		wr(A_CTRL, 32'h0);
		$display("Shift mode test done");
		test_done();
	end
endmodule // tb_serial_port_zero_uart
bind spzu_serial_port spzu_monitor spzu_monitor_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.serial_rx_pin_in(serial_rx_pin_in), .serial_rx_pin_out(serial_rx_pin_out), .serial_rx_pin_oe(serial_rx_pin_oe),
	.serial_tx_pin(serial_tx_pin));
`default_nettype wire
